// *** rtl/nsl_ctrl.sv ***
`timescale 1ns/10ps
// What this block does
// [RULE_01] read-only busy bit is 1 while a save or load runs, 0 when done
// [RULE_02] status pin shows busy whenever the status source select is set
// [RULE_03] read-only error bit is 1 when bad data was seen during a load
// [RULE_04] with select pin low, writing reload bit reloads from nonvolatile store, self-clears
// [RULE_05] store stays write protected unless the write-enable bit is 1; default 0; checked only at save start, a running save still writes if cleared
// [RULE_06] host waits at least 10 us after a transfer before starting another
// [RULE_07] writing 1 to the save bit starts copying buffer registers into the store
// [RULE_08] save bit returns to 0 by itself once the save has finished
// [RULE_09] upper bits of the four control registers have no function, read zero
// [RULE_10] busy stays high for the whole reload as it does for a save
// [RULE_11] save requested while write protected changes nothing and never runs
// [RULE_12] command byte with top bit 0 moves low seven bits plus one bytes
// [RULE_13] next two bytes after such a command give start address, high byte first
// [RULE_14] command byte with top bit 1 is update opcode or end-of-data terminator
// [RULE_15] buffer segment writer puts an end-of-data opcode in its last byte
module nsl_ctrl (
    input  wire logic                         ref_clk_in,
    input  wire logic                         rst_in,
    input  wire nsl_pkg::nsl_reg_wr_t         reg_wr_in,
    input  wire logic [11:0]                  reg_raddr_in,
    output logic      [7:0]                   reg_rdata_out,
    input  wire logic                         nvm_sel_n_in,
    input  wire logic                         status_sel_in,
    input  wire logic                         status_alt_in,
    output logic                              status_pin_out,
    output logic                              soft_reset_out,
    output logic                              io_update_out,
    output logic      [11:0]                  bank_addr_out,
    input  wire logic [7:0]                   bank_rdata_in,
    output logic                              bank_we_out,
    output logic      [11:0]                  bank_waddr_out,
    output logic      [7:0]                   bank_wdata_out,
    output logic                              nvm_req_out,
    output logic                              nvm_we_out,
    output logic      [nsl_pkg::NVM_AW-1:0]   nvm_addr_out,
    output logic      [7:0]                   nvm_wdata_out,
    input  wire logic                         nvm_ack_in,
    input  wire logic [7:0]                   nvm_rdata_in,
    input  wire logic                         nvm_err_in
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    nsl_pkg::nsl_state_t          state_r;
    nsl_pkg::nsl_phase_t          phase_r;
    logic                         save_r;
    logic                         wr_en_r;
    logic                         err_r;
    logic [11:0]                  seg_ptr_r;
    logic [15:0]                  data_addr_r;
    logic [6:0]                   cnt_r;
    logic [7:0]                   byte_r;
    logic [nsl_pkg::NVM_AW-1:0]   nvm_ptr_r;
    logic                         start_save;
    logic                         start_load;
    logic                         accept;
    logic [7:0]                   in_byte;
    logic                         busy;
    logic                         finish;

    function automatic logic is_wr(input nsl_pkg::nsl_reg_wr_t w, input logic [11:0] a, input int b);
        is_wr = w.we && (w.addr == a) && w.data[b];
    endfunction : is_wr

    assign busy       = (state_r != nsl_pkg::ST_IDLE); // [RULE_01] [RULE_10]
    // protected store: save request dropped, nothing written
    assign start_save = (state_r == nsl_pkg::ST_IDLE) && wr_en_r
                        && is_wr(reg_wr_in, nsl_pkg::ADDR_SAVE, nsl_pkg::BIT_SAVE); // [RULE_07] [RULE_11] [RULE_05]
    assign start_load = (state_r == nsl_pkg::ST_IDLE) && !nvm_sel_n_in
                        && is_wr(reg_wr_in, nsl_pkg::ADDR_RELOAD_WE, nsl_pkg::BIT_RELOAD); // [RULE_04]
    assign accept     = (state_r == nsl_pkg::ST_XFER) && nvm_ack_in;
    assign in_byte    = save_r ? byte_r : nvm_rdata_in;
    // last seg byte read in command phase or store end without terminator ends the walk; err_r is not set
    assign finish     = accept && (((phase_r == nsl_pkg::PH_CMD) && in_byte[nsl_pkg::CMD_OP_BIT]
                        && (in_byte == nsl_pkg::OP_END))
                        || ((phase_r == nsl_pkg::PH_CMD) && (seg_ptr_r == nsl_pkg::SEG_LAST))
                        || (nvm_ptr_r == nsl_pkg::NVM_LAST)); // [RULE_14] [RULE_15]
    assign bank_addr_out = (phase_r == nsl_pkg::PH_DATA) ? data_addr_r[11:0] : seg_ptr_r;
    assign nvm_req_out   = (state_r == nsl_pkg::ST_XFER);
    assign nvm_we_out    = save_r && (state_r == nsl_pkg::ST_XFER); // [RULE_05]
    assign nvm_addr_out  = nvm_ptr_r;
    assign nvm_wdata_out = byte_r;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_r <= nsl_pkg::ST_IDLE;
            save_r  <= 1'b0;
        end else begin
            case (state_r)
                nsl_pkg::ST_IDLE: begin
                    if (start_save || start_load) begin
                        state_r <= nsl_pkg::ST_FETCH;
                        save_r  <= start_save;
                    end
                end
                nsl_pkg::ST_FETCH: state_r <= nsl_pkg::ST_XFER;
                nsl_pkg::ST_XFER: begin
                    if (finish) begin
                        state_r <= nsl_pkg::ST_DONE;
                    end else if (accept) begin
                        state_r <= nsl_pkg::ST_FETCH;
                    end
                end
                nsl_pkg::ST_DONE: state_r <= nsl_pkg::ST_IDLE; // [RULE_08]
                default: state_r <= nsl_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // command stream parser
    // ----------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            phase_r     <= nsl_pkg::PH_CMD;
            seg_ptr_r   <= nsl_pkg::SEG_FIRST;
            data_addr_r <= 16'h0000;
            cnt_r       <= 7'h00;
            nvm_ptr_r   <= '0;
        end else if (state_r == nsl_pkg::ST_IDLE) begin
            phase_r   <= nsl_pkg::PH_CMD;
            seg_ptr_r <= nsl_pkg::SEG_FIRST;
            nvm_ptr_r <= '0;
        end else if (accept) begin
            nvm_ptr_r <= nvm_ptr_r + 10'h001;
            case (phase_r)
                nsl_pkg::PH_CMD: begin
                    seg_ptr_r <= seg_ptr_r + 12'h001;
                    if (!in_byte[nsl_pkg::CMD_OP_BIT]) begin
                        cnt_r   <= in_byte[6:0]; // [RULE_12]
                        phase_r <= nsl_pkg::PH_AHI;
                    end
                end
                nsl_pkg::PH_AHI: begin
                    seg_ptr_r          <= seg_ptr_r + 12'h001;
                    data_addr_r[15:8]  <= in_byte; // [RULE_13]
                    phase_r            <= nsl_pkg::PH_ALO;
                end
                nsl_pkg::PH_ALO: begin
                    seg_ptr_r          <= seg_ptr_r + 12'h001;
                    data_addr_r[7:0]   <= in_byte; // [RULE_13]
                    phase_r            <= nsl_pkg::PH_DATA;
                end
                nsl_pkg::PH_DATA: begin
                    data_addr_r <= data_addr_r + 16'h0001;
                    cnt_r       <= cnt_r - 7'h01;
                    if (cnt_r == 7'h00) begin
                        phase_r <= nsl_pkg::PH_CMD; // [RULE_12]
                    end
                end
                default: phase_r <= nsl_pkg::PH_CMD;
            endcase
        end
    end

    // ----------------------------------------
    // data movement
    // ----------------------------------------
    // bank read is combinational, so the fetch cycle latches it for the store write
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            byte_r         <= 8'h00;
            bank_we_out    <= 1'b0;
            bank_waddr_out <= 12'h000;
            bank_wdata_out <= 8'h00;
            io_update_out  <= 1'b0;
        end else begin
            if (state_r == nsl_pkg::ST_FETCH && save_r) begin
                byte_r <= bank_rdata_in; // [RULE_07]
            end
            bank_we_out    <= accept && !save_r;
            bank_waddr_out <= bank_addr_out;
            bank_wdata_out <= in_byte;
            io_update_out  <= accept && (phase_r == nsl_pkg::PH_CMD)
                              && (in_byte == nsl_pkg::OP_UPDATE); // [RULE_14]
        end
    end

    // ----------------------------------------
    // control and status bits
    // ----------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wr_en_r        <= nsl_pkg::RST_WR_ENABLE; // [RULE_05]
            err_r          <= 1'b0;
            soft_reset_out <= 1'b0;
            status_pin_out <= 1'b0;
        end else begin
            if (reg_wr_in.we && reg_wr_in.addr == nsl_pkg::ADDR_RELOAD_WE) begin
                wr_en_r <= reg_wr_in.data[nsl_pkg::BIT_WR_ENABLE]; // [RULE_05]
            end
            // fresh load clears; a bad byte later in that load sets
            if (accept && !save_r && nvm_err_in) begin
                err_r <= 1'b1; // [RULE_03]
            end else if (start_load) begin
                err_r <= 1'b0;
            end
            soft_reset_out <= start_load; // [RULE_04]
            status_pin_out <= status_sel_in ? busy : status_alt_in; // [RULE_02]
        end
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= 8'h00; // [RULE_09]
            case (reg_raddr_in)
                nsl_pkg::ADDR_BUSY:  reg_rdata_out[nsl_pkg::BIT_BUSY]  <= busy; // [RULE_01]
                nsl_pkg::ADDR_ERROR: reg_rdata_out[nsl_pkg::BIT_ERROR] <= err_r; // [RULE_03]
                nsl_pkg::ADDR_RELOAD_WE: begin
                    reg_rdata_out[nsl_pkg::BIT_RELOAD]    <= busy && !save_r; // [RULE_04]
                    reg_rdata_out[nsl_pkg::BIT_WR_ENABLE] <= wr_en_r;
                end
                nsl_pkg::ADDR_SAVE:  reg_rdata_out[nsl_pkg::BIT_SAVE]  <= busy && save_r; // [RULE_08]
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_busy_start;
        @(posedge ref_clk_in) disable iff (rst_in)
        (start_save || start_load) |=> busy[*2];
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not raised on start"); // [RULE_01]

    property p_status_pin;
        @(posedge ref_clk_in) disable iff (rst_in)
        status_sel_in |=> (status_pin_out == $past(busy));
    endproperty
    a_status_pin: assert property (p_status_pin) else $error("status pin not following busy"); // [RULE_02]

    property p_err_set;
        @(posedge ref_clk_in) disable iff (rst_in)
        (accept && !save_r && nvm_err_in) |=> err_r;
    endproperty
    a_err_set: assert property (p_err_set) else $error("load error not flagged"); // [RULE_03]

    property p_reload;
        @(posedge ref_clk_in) disable iff (rst_in)
        start_load |=> (soft_reset_out && !save_r && state_r == nsl_pkg::ST_FETCH);
    endproperty
    a_reload: assert property (p_reload) else $error("reload did not start"); // [RULE_04]

    property p_protect;
        @(posedge ref_clk_in) disable iff (rst_in)
        (state_r == nsl_pkg::ST_IDLE && !wr_en_r) |=> ##1 !nvm_we_out;
    endproperty
    a_protect: assert property (p_protect) else $error("store written while protected"); // [RULE_05]

    property p_no_save_locked;
        @(posedge ref_clk_in) disable iff (rst_in)
        (state_r == nsl_pkg::ST_IDLE && !wr_en_r) |=> !(busy && save_r);
    endproperty
    a_no_save_locked: assert property (p_no_save_locked) else $error("save ran while protected"); // [RULE_11]

    property p_self_clear;
        @(posedge ref_clk_in) disable iff (rst_in)
        (state_r == nsl_pkg::ST_DONE) |=> ##1 ($past(reg_raddr_in) != nsl_pkg::ADDR_SAVE
                                                || !reg_rdata_out[nsl_pkg::BIT_SAVE]);
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("save bit did not clear"); // [RULE_08]

    property p_len;
        @(posedge ref_clk_in) disable iff (rst_in)
        (accept && phase_r == nsl_pkg::PH_CMD && !in_byte[7] && !finish)
            |=> (cnt_r == $past(in_byte[6:0]) && phase_r == nsl_pkg::PH_AHI);
    endproperty
    a_len: assert property (p_len) else $error("transfer length wrong"); // [RULE_12]

    property p_end;
        @(posedge ref_clk_in) disable iff (rst_in)
        (accept && phase_r == nsl_pkg::PH_CMD && in_byte == nsl_pkg::OP_END) |=> ##1 !busy;
    endproperty
    a_end: assert property (p_end) else $error("end opcode did not stop"); // [RULE_14]
endmodule : nsl_ctrl

// *** rtl/nsl_pkg.sv ***
package nsl_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [11:0] ADDR_BUSY      = 12'hB00;
    localparam logic [11:0] ADDR_ERROR     = 12'hB01;
    localparam logic [11:0] ADDR_RELOAD_WE = 12'hB02;
    localparam logic [11:0] ADDR_SAVE      = 12'hB03;
    localparam int          BIT_WR_ENABLE  = 0;
    localparam int          BIT_RELOAD     = 1;
    localparam int          BIT_SAVE       = 0;
    localparam int          BIT_BUSY       = 0;
    localparam int          BIT_ERROR      = 0;
    localparam logic        RST_WR_ENABLE  = 1'b0;
    // ----------------------------------------
    // buffer segment and command stream
    // ----------------------------------------
    localparam logic [11:0] SEG_FIRST      = 12'hA00;
    localparam logic [11:0] SEG_LAST       = 12'hAFF;
    localparam int          CMD_OP_BIT     = 7;
    localparam logic [7:0]  OP_UPDATE      = 8'h80;
    localparam logic [7:0]  OP_END         = 8'hFF;
    localparam int          NVM_AW         = 10;
    localparam logic [NVM_AW-1:0] NVM_LAST = 10'h3FF;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic        we;
        logic [11:0] addr;
        logic [7:0]  data;
    } nsl_reg_wr_t;

    typedef enum logic [1:0] {
        PH_CMD  = 2'h0,
        PH_AHI  = 2'h1,
        PH_ALO  = 2'h2,
        PH_DATA = 2'h3
    } nsl_phase_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_XFER  = 4'b0100,
        ST_DONE  = 4'b1000
    } nsl_state_t;
endpackage : nsl_pkg

// *** dv/nsl_nvm_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// nonvolatile store model, far side of the stream
// ----------------------------------------
module nsl_nvm_model (
    input  wire logic       ref_clk_in,
    input  wire logic       req_in,
    input  wire logic       we_in,
    input  wire logic [9:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       err_mode_in,
    output logic            ack_out,
    output logic      [7:0] rdata_out,
    output logic            err_out
);
    logic [7:0] mem [0:1023];
    logic [2:0] cnt_r;
    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 8'hEE;
        ack_out   = 1'b0;
        rdata_out = 8'h00;
        err_out   = 1'b0;
        cnt_r     = 3'h0;
    end
    // odd addresses answer slowly, even ones promptly
    always @(posedge ref_clk_in) begin
        ack_out   <= 1'b0;
        err_out   <= 1'b0;
        rdata_out <= ~rdata_out; // stale data inverts every cycle outside a read ack
        if (req_in && !ack_out) begin
            if (cnt_r == (addr_in[0] ? 3'h4 : 3'h0)) begin
                ack_out <= 1'b1;
                cnt_r   <= 3'h0;
                if (we_in) mem[addr_in] <= wdata_in;
                else begin
                    rdata_out <= mem[addr_in];
                    err_out   <= err_mode_in;
                end
            end else cnt_r <= cnt_r + 3'h1;
        end
    end
endmodule : nsl_nvm_model

// *** dv/nsl_ctrl_tb_top.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module nsl_ctrl_tb_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic                 ref_clk_in = 1'b0, rst_in = 1'b1, nvm_sel_n = 1'b0, stat_sel = 1'b0, stat_alt = 1'b0;
    logic                 pin, soft_rst, io_upd, bank_we, nvm_req, nvm_we, nvm_ack, nvm_err, err_mode = 1'b0;
    nsl_pkg::nsl_reg_wr_t reg_wr = '0;
    logic [11:0]          raddr = 12'h000, bank_addr, bank_waddr;
    logic [7:0]           rdata, bank_wdata, nvm_wdata, nvm_rdata, v;
    logic [9:0]           nvm_addr;
    logic [7:0]           bank [0:4095];
    int                   errors = 0, samples_checked = 0, sr_cnt = 0, io_cnt = 0;
    initial forever #5 ref_clk_in = ~ref_clk_in;
    nsl_ctrl u_nsl_ctrl (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr), .reg_raddr_in(raddr),
        .reg_rdata_out(rdata), .nvm_sel_n_in(nvm_sel_n), .status_sel_in(stat_sel), .status_alt_in(stat_alt),
        .status_pin_out(pin), .soft_reset_out(soft_rst), .io_update_out(io_upd), .bank_addr_out(bank_addr),
        .bank_rdata_in(bank[bank_addr]), .bank_we_out(bank_we), .bank_waddr_out(bank_waddr),
        .bank_wdata_out(bank_wdata), .nvm_req_out(nvm_req), .nvm_we_out(nvm_we), .nvm_addr_out(nvm_addr),
        .nvm_wdata_out(nvm_wdata), .nvm_ack_in(nvm_ack), .nvm_rdata_in(nvm_rdata), .nvm_err_in(nvm_err));
    nsl_nvm_model u_nsl_nvm_model (.ref_clk_in(ref_clk_in), .req_in(nvm_req), .we_in(nvm_we),
        .addr_in(nvm_addr), .wdata_in(nvm_wdata), .err_mode_in(err_mode), .ack_out(nvm_ack),
        .rdata_out(nvm_rdata), .err_out(nvm_err));
    always @(posedge ref_clk_in) begin
        if (soft_rst === 1'b1) sr_cnt++;
        if (io_upd === 1'b1) io_cnt++;
        if (bank_we === 1'b1) bank[bank_waddr] <= bank_wdata;
    end
    // ----------------------------------------
    // register access tasks
    // ----------------------------------------
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        reg_wr = '{we: 1'b1, addr: a, data: d};
        @(negedge ref_clk_in);
        reg_wr.we = 1'b0;
    endtask : wr
    task rd(input logic [11:0] a, output logic [7:0] d);
        @(negedge ref_clk_in);
        raddr = a;
        @(negedge ref_clk_in);
        d = rdata;
    endtask : rd
    task give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // bounded poll, then the host pause between transfers
    task wait_idle();
        v = 8'h01;
        for (int i = 0; i < 3000 && v[0] !== 1'b0; i++) rd(nsl_pkg::ADDR_BUSY, v);
        if (v[0] !== 1'b0) begin
            errors++;
            give_verdict();
        end
        repeat (1000) @(negedge ref_clk_in);
    endtask : wait_idle
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 4096; i++) bank[i] = 8'h00;
        bank[12'hA00] = 8'h01;
        bank[12'hA01] = 8'h00;
        bank[12'hA02] = 8'h10;
        bank[12'hA03] = nsl_pkg::OP_UPDATE;
        // unknown opcode: walked over, moves nothing
        bank[12'hA04] = 8'h81;
        bank[12'hA05] = nsl_pkg::OP_END;
        bank[12'hAFF] = nsl_pkg::OP_END;
        bank[12'h010] = 8'h5A;
        bank[12'h011] = 8'hC3;
        repeat (3) @(negedge ref_clk_in);
        rst_in = 1'b0;
        for (int a = 0; a < 4; a++) begin
            rd(nsl_pkg::ADDR_BUSY + a[11:0], v);
            `CHK(v, 8'h00)
        end
        wr(nsl_pkg::ADDR_SAVE, 8'hFF);
        rd(nsl_pkg::ADDR_BUSY, v);
        `CHK(v, 8'h00)
        `CHK(u_nsl_nvm_model.mem[0], 8'hEE)
        stat_sel = 1'b1;
        wr(nsl_pkg::ADDR_RELOAD_WE, 8'h01);
        wr(nsl_pkg::ADDR_SAVE, 8'h01);
        rd(nsl_pkg::ADDR_BUSY, v);
        `CHK(v, 8'h01)
        `CHK(pin, 1'b1)
        wait_idle();
        rd(nsl_pkg::ADDR_SAVE, v);
        `CHK(v, 8'h00)
        `CHK(pin, 1'b0)
        `CHK(u_nsl_nvm_model.mem[0], 8'h01)
        `CHK(u_nsl_nvm_model.mem[3], 8'h5A)
        `CHK(u_nsl_nvm_model.mem[4], 8'hC3)
        `CHK(u_nsl_nvm_model.mem[5], nsl_pkg::OP_UPDATE)
        `CHK(u_nsl_nvm_model.mem[6], 8'h81)
        `CHK(u_nsl_nvm_model.mem[7], nsl_pkg::OP_END)
        `CHK(u_nsl_nvm_model.mem[8], 8'hEE)
        `CHK(io_cnt, 1)
        stat_sel = 1'b0;
        stat_alt = 1'b1;
        repeat (2) @(negedge ref_clk_in);
        `CHK(pin, 1'b1)
        bank[12'h010] = 8'h00;
        bank[12'h011] = 8'h00;
        nvm_sel_n = 1'b1;
        wr(nsl_pkg::ADDR_RELOAD_WE, 8'h03);
        rd(nsl_pkg::ADDR_BUSY, v);
        `CHK(v, 8'h00)
        nvm_sel_n = 1'b0;
        wr(nsl_pkg::ADDR_RELOAD_WE, 8'h03);
        rd(nsl_pkg::ADDR_RELOAD_WE, v);
        `CHK(v, 8'h03)
        `CHK(sr_cnt, 1)
        wait_idle();
        rd(nsl_pkg::ADDR_RELOAD_WE, v);
        `CHK(v, 8'h01)
        `CHK(bank[12'h010], 8'h5A)
        `CHK(bank[12'h011], 8'hC3)
        `CHK(bank[12'hA04], 8'h81)
        `CHK(io_cnt, 2)
        rd(nsl_pkg::ADDR_ERROR, v);
        `CHK(v, 8'h00)
        err_mode = 1'b1;
        wr(nsl_pkg::ADDR_RELOAD_WE, 8'h03);
        wait_idle();
        rd(nsl_pkg::ADDR_ERROR, v);
        `CHK(v, 8'h01)
        give_verdict();
    end
endmodule : nsl_ctrl_tb_top
